// ### core/dpsc_host.sv
// Purpose: host controller for one port of an asynchronous dual-port sram
// Assumes: single 100 MHz clock, sram pins sampled through synchronisers
// Notes: one access at a time; commands during an access or sleep are refused
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - no test clock while port sleeps
// - semaphore read with chip enables inactive
// - semaphore write on read/write rising edge
// - semaphore read needs a lane select
// - test clock at most 10 MHz
module dpsc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    output dpsc_pkg::dpsc_pins_t sram_pins_o,
    output logic [dpsc_pkg::AW-1:0] sram_addr_o,
    input wire logic [dpsc_pkg::DW-1:0] dq_i,
    output logic [dpsc_pkg::DW-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic busy_i,
    output logic busy_o,
    output logic busy_oe_o,
    output logic master_slave_o,
    output logic sleep_request_o,
    output logic io_level_option_o,
    output dpsc_pkg::dpsc_jtag_t jtag_o,
    input wire logic tdo_i
);
    import dpsc_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    // ops that sample the data bus
    function automatic logic is_rd(input dpsc_op_t op);
        is_rd = (op == OP_READ) || (op == OP_SEM_RD);
    endfunction : is_rd

    // ops that go through the flags, not the array
    function automatic logic is_sem(input dpsc_op_t op);
        is_sem = (op == OP_SEM_RD) || (op == OP_SEM_WR);
    endfunction : is_sem

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [SW-1:0] s1; // first stage, read only by s2
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] filt; // settled view of the pins
    logic [SW-1:0] next_filt;

    // a bit moves only once stages two and three agree
    always_comb
    begin
        next_filt = (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end

    // three-stage chain plus settled value
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end
        else
        begin
            s1 <= {tdo_i, busy_i, dq_i};
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end

    // ************************************************************
    // control state
    // ************************************************************
    dpsc_ctl_t ctl; // all control flops
    dpsc_ctl_t next_ctl;
    logic [STAT_W-1:0] stat; // status word
    logic cmd_hit; // command register written
    logic sleeping;
    logic lane_u;
    logic lane_l;

    // register port, access sequencer and test clock divider
    always_comb
    begin
        next_ctl = ctl;
        sleeping = ctl.cfg[CFG_SLEEP];
        cmd_hit = reg_we_i && (reg_addr_i == REG_CMD);
        lane_u = reg_wdata_i[CMD_UB];
        lane_l = reg_wdata_i[CMD_LB];
        stat = '0;
        stat[ST_BUSY] = (ctl.state != ST_IDLE);
        stat[ST_GRANT] = ctl.grant;
        stat[ST_BUSYPIN] = filt[DW];
        stat[ST_TDO] = filt[DW+1];
        stat[ST_REFUSED] = ctl.refused;
        // register writes; cfg only changes while idle so sleep never cuts an access
        if (reg_we_i)
        begin
            if (reg_addr_i == REG_ADDR)
            begin
                next_ctl.addr = reg_wdata_i[AW-1:0];
            end
            else if (reg_addr_i == REG_WDATA)
            begin
                next_ctl.wdata = reg_wdata_i[DW-1:0];
            end
            else if (reg_addr_i == REG_STAT)
            begin
                if (reg_wdata_i[ST_REFUSED])
                begin
                    next_ctl.refused = 1'b0; // w1c, set below wins
                end
            end
            else if (reg_addr_i == REG_CFG)
            begin
                if (ctl.state == ST_IDLE)
                begin
                    next_ctl.cfg = reg_wdata_i[CFG_W-1:0];
                end
                else
                begin
                    next_ctl.refused = 1'b1;
                end
            end
        end
        // read data stands in the following cycle only
        next_ctl.rd_out = '0;
        if (reg_re_i)
        begin
            if (reg_addr_i == REG_ADDR)
            begin
                next_ctl.rd_out = 32'(ctl.addr);
            end
            else if (reg_addr_i == REG_WDATA)
            begin
                next_ctl.rd_out = 32'(ctl.wdata);
            end
            else if (reg_addr_i == REG_RDATA)
            begin
                next_ctl.rd_out = 32'(ctl.rdata);
            end
            else if (reg_addr_i == REG_STAT)
            begin
                next_ctl.rd_out = 32'(stat);
            end
            else if (reg_addr_i == REG_CFG)
            begin
                next_ctl.rd_out = 32'(ctl.cfg);
            end
        end
        // access sequencer
        case (ctl.state)
            ST_IDLE:
            begin
                if (cmd_hit && sleeping)
                begin
                    next_ctl.refused = 1'b1;
                end
                else if (cmd_hit)
                begin
                    next_ctl.op = dpsc_op_t'(reg_wdata_i[CMD_OP_MSB:CMD_OP_LSB]);
                    next_ctl.pins.upper_byte_select_n = ~lane_u;
                    next_ctl.pins.lower_byte_select_n = ~lane_l;
                    if (next_ctl.op == OP_SEM_RD && !lane_u && !lane_l)
                    begin
                        next_ctl.pins.lower_byte_select_n = 1'b0;
                    end
                    if (next_ctl.op == OP_SEM_WR)
                    begin
                        next_ctl.pins.lower_byte_select_n = 1'b0;
                    end
                    if (is_sem(next_ctl.op))
                    begin
                        next_ctl.pins.semaphore_select_n = 1'b0;
                    end
                    else
                    begin
                        next_ctl.pins.chip_enable_low_active_n = 1'b0;
                        next_ctl.pins.chip_enable_high_active = 1'b1;
                    end
                    next_ctl.state = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // address and selects have settled for one cycle
                if (is_rd(ctl.op))
                begin
                    next_ctl.pins.output_enable_n = 1'b0;
                end
                else
                begin
                    next_ctl.pins.read_not_write = 1'b0;
                    next_ctl.dq_oe = 1'b1;
                end
                next_ctl.cnt = '0;
                next_ctl.state = ST_STROBE;
            end
            ST_STROBE:
            begin
                // wait covers access time plus the synchroniser delay
                next_ctl.cnt = ctl.cnt + 4'h1;
                if (ctl.cnt == WAIT_LAST)
                begin
                    next_ctl.pins.read_not_write = 1'b1;
                    next_ctl.pins.output_enable_n = 1'b1;
                    if (is_rd(ctl.op))
                    begin
                        next_ctl.rdata = filt[DW-1:0];
                    end
                    if (ctl.op == OP_SEM_RD)
                    begin
                        next_ctl.grant = ~filt[0];
                    end
                    next_ctl.state = ST_DONE;
                end
            end
            default:
            begin
                // selects held one cycle past the write edge
                next_ctl.pins = PINS_IDLE;
                next_ctl.dq_oe = 1'b0;
                next_ctl.state = ST_IDLE;
            end
        endcase
        if (cmd_hit && ctl.state != ST_IDLE)
        begin
            next_ctl.refused = 1'b1;
        end
        // test clock: half period of whole cycles, stopped in sleep
        if (ctl.cfg[CFG_TCK_EN] && !sleeping)
        begin
            next_ctl.tck_cnt = ctl.tck_cnt + 4'h1;
            if (ctl.tck_cnt == TCK_LAST)
            begin
                next_ctl.tck_cnt = '0;
                next_ctl.tck = ~ctl.tck;
            end
        end
        else
        begin
            next_ctl.tck_cnt = '0;
            next_ctl.tck = 1'b0;
        end
    end

    // control flops
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctl <= '{state: ST_IDLE, op: OP_READ, pins: PINS_IDLE, cfg: CFG_RST, default: '0};
        end
        else
        begin
            ctl <= next_ctl;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata_o = ctl.rd_out;
    assign sram_pins_o = ctl.pins;
    assign sram_addr_o = ctl.addr;
    assign dq_o = ctl.wdata; // bit 0 carries the flag value
    assign dq_oe_o = ctl.dq_oe;
    assign busy_o = 1'b1; // inactive level toward a slave device
    assign busy_oe_o = ~ctl.cfg[CFG_MS];
    assign master_slave_o = ctl.cfg[CFG_MS];
    assign sleep_request_o = ctl.cfg[CFG_SLEEP];
    assign io_level_option_o = ctl.cfg[CFG_OPT];
    assign jtag_o = '{ctl.tck, ctl.cfg[CFG_TMS], ctl.cfg[CFG_TDI], ~ctl.cfg[CFG_TRST]};

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence sem_wr_low;
        !ctl.pins.semaphore_select_n && !ctl.pins.read_not_write && !ctl.pins.lower_byte_select_n;
    endsequence
    sequence sem_wr_rise;
        !ctl.pins.semaphore_select_n && ctl.pins.read_not_write && !ctl.pins.lower_byte_select_n
            && dq_oe_o;
    endsequence

    a_sem_no_ce: assert property (!sram_pins_o.semaphore_select_n |->
        sram_pins_o.chip_enable_low_active_n && !sram_pins_o.chip_enable_high_active)
        else $error("semaphore select with chip enable");
    a_ce_select: assert property (ctl.state == ST_STROBE && !is_sem(ctl.op) |->
        !sram_pins_o.chip_enable_low_active_n && sram_pins_o.chip_enable_high_active)
        else $error("access without chip enables");
    a_write_lanes: assert property (!sram_pins_o.read_not_write |->
        dq_oe_o && (!sram_pins_o.upper_byte_select_n || !sram_pins_o.lower_byte_select_n))
        else $error("write without lane or data drive");
    a_oe_length: assert property ($fell(sram_pins_o.output_enable_n) |->
        (!sram_pins_o.output_enable_n && !dq_oe_o) [*5] ##1 sram_pins_o.output_enable_n)
        else $error("output enable strobe length wrong");
    a_sleep_quiet: assert property (sleep_request_o |->
        !dq_oe_o && sram_pins_o == PINS_IDLE && !jtag_o.test_clock)
        else $error("activity during sleep");
    a_sem_wr_edge: assert property (sem_wr_low ##1 sram_pins_o.read_not_write |-> sem_wr_rise)
        else $error("semaphore write edge lost select");
    a_sem_rd_lane: assert property (!sram_pins_o.semaphore_select_n &&
        !sram_pins_o.output_enable_n |-> !sram_pins_o.upper_byte_select_n ||
        !sram_pins_o.lower_byte_select_n)
        else $error("semaphore read without lane");
    a_grant_flag: assert property (ctl.state == ST_DONE && ctl.op == OP_SEM_RD |->
        ctl.grant == ~ctl.rdata[0])
        else $error("grant does not follow flag");
    a_tck_half: assert property ($rose(jtag_o.test_clock) |->
        jtag_o.test_clock [*5])
        else $error("test clock too fast");
    a_busy_dir: assert property ($changed(master_slave_o) |-> busy_oe_o != master_slave_o)
        else $error("busy pin direction wrong");

endmodule : dpsc_host

`default_nettype wire

// ### core/dpsc_pkg.sv
// Purpose: shared constants and types for the dual-port sram port host
// Assumes: 100 MHz system clock, one sram port driven by this host
// Notes: register offsets are byte addresses on the local register port
package dpsc_pkg;

    // ************************************************************
    // widths and register map
    // ************************************************************
    localparam int AW = 19; // sram address bits
    localparam int DW = 18; // sram data bits, two 9-bit lanes
    localparam int SW = DW + 2; // synchronised inputs: data, busy, tdo
    localparam logic [4:0] REG_CMD = 5'h00; // write starts an access
    localparam logic [4:0] REG_ADDR = 5'h04; // sram address
    localparam logic [4:0] REG_WDATA = 5'h08; // write data
    localparam logic [4:0] REG_RDATA = 5'h0c; // last read data
    localparam logic [4:0] REG_STAT = 5'h10; // status, refused is w1c
    localparam logic [4:0] REG_CFG = 5'h14; // pin levels and test port

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_MSB = 1;
    localparam int CMD_UB = 2; // use upper lane
    localparam int CMD_LB = 3; // use lower lane
    localparam int CFG_W = 7;
    localparam int CFG_SLEEP = 0;
    localparam int CFG_OPT = 1;
    localparam int CFG_MS = 2; // 1 = device is master
    localparam int CFG_TCK_EN = 3;
    localparam int CFG_TMS = 4;
    localparam int CFG_TDI = 5;
    localparam int CFG_TRST = 6; // 1 = hold test reset
    localparam logic [CFG_W-1:0] CFG_RST = 7'h40; // test port held in reset
    localparam int STAT_W = 5;
    localparam int ST_BUSY = 0;
    localparam int ST_GRANT = 1;
    localparam int ST_BUSYPIN = 2;
    localparam int ST_TDO = 3;
    localparam int ST_REFUSED = 4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS = 10;
    localparam int CLK_MHZ = 100;
    localparam int ACC_NS = 15; // slowest access time served
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC = 3; // input synchroniser depth
    localparam int WAIT_CYC = ACC_CYC + SYNC_CYC;
    localparam logic [3:0] WAIT_LAST = 4'(WAIT_CYC - 1);
    localparam int TCK_MAX_MHZ = 10;
    localparam int TCK_HALF = (CLK_MHZ + 2 * TCK_MAX_MHZ - 1) / (2 * TCK_MAX_MHZ);
    localparam logic [3:0] TCK_LAST = 4'(TCK_HALF - 1);

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SEM_RD, OP_SEM_WR} dpsc_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_DONE} dpsc_state_t;
    typedef struct packed {
        logic chip_enable_low_active_n;
        logic chip_enable_high_active;
        logic semaphore_select_n;
        logic upper_byte_select_n;
        logic lower_byte_select_n;
        logic read_not_write;
        logic output_enable_n;
    } dpsc_pins_t;
    localparam dpsc_pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    typedef struct packed {
        logic test_clock;
        logic test_mode_select;
        logic test_data_in;
        logic test_reset_n;
    } dpsc_jtag_t;
    typedef struct packed {
        dpsc_state_t state;
        dpsc_op_t op;
        logic [3:0] cnt;
        dpsc_pins_t pins;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [DW-1:0] rdata;
        logic dq_oe;
        logic grant;
        logic refused;
        logic [CFG_W-1:0] cfg;
        logic tck;
        logic [3:0] tck_cnt;
        logic [31:0] rd_out;
    } dpsc_ctl_t;

endpackage : dpsc_pkg

// ### sim/dpsc_sram_model.sv
// Purpose: behavioural model of one port of the dual-port sram, for the host bench
// Assumes: pin levels from dpsc_host; answers are combinational
// Notes: undriven lanes show inverted data, so a stale value can never pass
`timescale 1ns/1ps
`default_nettype none

module dpsc_sram_model
    import dpsc_pkg::*;
(
    input wire dpsc_pkg::dpsc_pins_t pins_i,
    input wire logic [dpsc_pkg::AW-1:0] addr_i,
    input wire logic [dpsc_pkg::DW-1:0] dq_i,
    input wire logic sleep_i,
    input wire logic ms_i,
    input wire dpsc_pkg::dpsc_jtag_t jtag_i,
    output logic [dpsc_pkg::DW-1:0] dq_o,
    output logic busy_oe_o,
    output logic busy_o,
    output logic tdo_o
);
    // ************************************************************
    // storage and decode
    // ************************************************************
    logic [DW-1:0] mem [16]; // small window, low address bits only
    logic [7:0] flag = 8'hff; // all flags free at power up
    logic [DW-1:0] val; // value the port would present
    logic sel; // normal access selected
    logic semaphore_select; // semaphore access selected
    logic up; // upper lane enabled
    logic lo; // lower lane enabled

    assign sel = !sleep_i && !pins_i.chip_enable_low_active_n && pins_i.chip_enable_high_active;
    assign semaphore_select = !sleep_i && !pins_i.semaphore_select_n && !sel;
    assign up = !pins_i.upper_byte_select_n;
    assign lo = !pins_i.lower_byte_select_n;
    assign busy_oe_o = ms_i;
    assign busy_o = 1'b0; // master reports a held location

    // read path: each lane drives only when enabled
    always_comb
    begin
        val = semaphore_select ? {DW{flag[addr_i[2:0]]}} : mem[addr_i[3:0]];
        dq_o = ~val;
        if ((sel || semaphore_select) && pins_i.read_not_write && !pins_i.output_enable_n)
        begin
            if (up) dq_o[17:9] = val[17:9];
            if (lo) dq_o[8:0] = val[8:0];
        end
    end

    // writes land on the rising read/write edge
    always @(posedge pins_i.read_not_write)
    begin
        if (sel && up) mem[addr_i[3:0]][17:9] <= dq_i[17:9];
        if (sel && lo) mem[addr_i[3:0]][8:0] <= dq_i[8:0];
        if (semaphore_select && lo) flag[addr_i[2:0]] <= dq_i[0];
    end

    // one-stage test path, cleared by test reset
    always @(posedge jtag_i.test_clock or negedge jtag_i.test_reset_n)
    begin
        if (!jtag_i.test_reset_n)
            tdo_o <= 1'b0;
        else
            tdo_o <= jtag_i.test_data_in;
    end
endmodule : dpsc_sram_model

`default_nettype wire

// ### sim/dual_port_sram_port_control_bench.sv
// Purpose: self-checking bench for the sram port host controller
// Assumes: 100 MHz clock, register port driven by non-blocking writes
// Notes: expected values come from the register map and the lane, semaphore, sleep and test clock rules
`timescale 1ns/1ps
`default_nettype none

module dual_port_sram_port_control_bench;
    import dpsc_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata;
    logic we;
    logic re;
    logic [31:0] rdata;
    dpsc_pins_t pins;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_bus, dq_host, dq_dev;
    logic dq_oe, busy_pin, busy_o, busy_oe, m_busy_oe, m_busy;
    logic ms, sleep, io_level_option, tdo;
    dpsc_jtag_t jtag;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] d;

    // host wins the data bus while it drives; busy pin has one driver per mode
    assign dq_bus = dq_oe ? dq_host : dq_dev;
    assign busy_pin = m_busy_oe ? m_busy : (busy_oe ? busy_o : 1'b1);

    dpsc_host dpsc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .sram_pins_o(pins), .sram_addr_o(addr), .dq_i(dq_bus), .dq_o(dq_host),
        .dq_oe_o(dq_oe), .busy_i(busy_pin), .busy_o(busy_o), .busy_oe_o(busy_oe),
        .master_slave_o(ms), .sleep_request_o(sleep), .io_level_option_o(io_level_option),
        .jtag_o(jtag), .tdo_i(tdo));
    dpsc_sram_model dpsc_sram_model_inst (.pins_i(pins), .addr_i(addr), .dq_i(dq_bus),
        .sleep_i(sleep), .ms_i(ms), .jtag_i(jtag), .dq_o(dq_dev), .busy_oe_o(m_busy_oe),
        .busy_o(m_busy), .tdo_o(tdo));

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr <= a;
        reg_wdata <= v;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk_i);
        reg_addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string n);
        logic [31:0] v;
        rd(a, v);
        chk(n, e, v & m);
    endtask : rchk

    // start one access and poll the busy bit, bounded
    task automatic acc(input logic [1:0] op, input logic ub, input logic lb);
        logic [31:0] s;
        wr(REG_CMD, {28'h0, lb, ub, op});
        s = 32'h1;
        for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
            rd(REG_STAT, s);
        chk("access done", 32'h0, {31'h0, s[0]});
    endtask : acc

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        reg_addr = 5'h00;
        reg_wdata = 32'h0;
        we = 1'b0;
        re = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("pins idle", {25'h0, PINS_IDLE}, {25'h0, pins});
        rchk(REG_CFG, 32'hffffffff, 32'h40, "cfg reset");
        rchk(5'h18, 32'hffffffff, 32'h0, "unmapped read");
        // full word, then lower lane only, then read back
        wr(REG_ADDR, 32'h5);
        wr(REG_WDATA, 32'h2a5c3);
        acc(2'd1, 1'b1, 1'b1);
        wr(REG_WDATA, 32'h11);
        acc(2'd1, 1'b0, 1'b1);
        acc(2'd0, 1'b1, 1'b1);
        rchk(REG_RDATA, 32'h3ffff, 32'h2a411, "lane merge");
        // claim flag 3, check a neighbour, its alias, then release
        wr(REG_ADDR, 32'h3);
        wr(REG_WDATA, 32'h0);
        acc(2'd3, 1'b0, 1'b1);
        wr(REG_ADDR, 32'h4);
        acc(2'd2, 1'b1, 1'b1);
        rchk(REG_RDATA, 32'h3ffff, 32'h3ffff, "free flag");
        rchk(REG_STAT, 32'h2, 32'h0, "no grant");
        wr(REG_ADDR, 32'hfff8000b);
        rchk(REG_ADDR, 32'hffffffff, 32'hb, "addr readback");
        acc(2'd2, 1'b1, 1'b1);
        rchk(REG_RDATA, 32'h3ffff, 32'h0, "owned flag");
        rchk(REG_STAT, 32'h2, 32'h2, "grant");
        wr(REG_WDATA, 32'h1);
        rchk(REG_WDATA, 32'hffffffff, 32'h1, "wdata readback");
        acc(2'd3, 1'b1, 1'b0);
        acc(2'd2, 1'b1, 1'b1);
        rchk(REG_RDATA, 32'h3ffff, 32'h3ffff, "released flag");
        // commands and pin levels are refused while an access runs
        wr(REG_CMD, 32'h6);
        wr(REG_CMD, 32'hc);
        wr(REG_CFG, 32'h41);
        rchk(REG_CFG, 32'hffffffff, 32'h40, "cfg kept while busy");
        rchk(REG_STAT, 32'h10, 32'h10, "refused while busy");
        wr(REG_STAT, 32'h10);
        // sleep refuses access; option and master select stay live
        wr(REG_CFG, 32'h43);
        wr(REG_CMD, 32'hc);
        rchk(REG_STAT, 32'h10, 32'h10, "refused in sleep");
        chk("sleep pin", 32'h1, {31'h0, sleep});
        chk("option pin", 32'h1, {31'h0, io_level_option});
        wr(REG_CFG, 32'h47);
        repeat (6) @(posedge clk_i);
        chk("master pin", 32'h1, {31'h0, ms});
        chk("busy released", 32'h0, {31'h0, busy_oe});
        wr(REG_STAT, 32'h10);
        rchk(REG_STAT, 32'h14, 32'h0, "refused clear, busy in");
        wr(REG_CFG, 32'h29);
        repeat (12)
        begin
            @(posedge clk_i);
            #1 chk("tck in sleep", 32'h0, {31'h0, jtag.test_clock});
        end
        // slave mode drives busy; test path runs out of reset
        wr(REG_CFG, 32'h38);
        // measure one high phase of the test clock in system cycles
        wait (jtag.test_clock === 1'b1);
        d = 32'h0;
        while (jtag.test_clock === 1'b1)
        begin
            @(posedge clk_i);
            #1 d = d + 32'h1;
        end
        chk("tck high cycles", 32'(TCK_HALF), d);
        repeat (30) @(posedge clk_i);
        chk("busy driven", 32'h1, {31'h0, busy_oe});
        chk("tms pin", 32'h1, {31'h0, jtag.test_mode_select});
        rchk(REG_STAT, 32'hc, 32'hc, "busy out, tdo");
        wr(REG_CFG, 32'h40);
        repeat (6) @(posedge clk_i);
        rchk(REG_STAT, 32'h8, 32'h0, "tdo reset");
        finish_test();
    end
endmodule : dual_port_sram_port_control_bench

`default_nettype wire
